// ### logic/gcm_pkg.sv
// Package for the PLL model and global clock line selection
package gcm_pkg;
    // Line and pin counts
    localparam int GCM_NUM_LINES   = 8;
    localparam int GCM_NUM_DED     = 4;
    localparam int GCM_NUM_DUAL    = 8;
    localparam int GCM_NUM_PLLOUT  = 2;
    localparam int GCM_REGION_W    = 6;
    localparam int GCM_CLUSTER_W   = 2;
    // Lock delay window in reference cycles
    localparam int GCM_LOCK_MIN    = 2;
    localparam int GCM_LOCK_MAX    = 10;
    localparam int GCM_LOCK_DEF    = 4;
    // Clock rate and reference measurement window
    localparam int GCM_SYS_MHZ     = 125;
    localparam int GCM_WIN_NS      = 1024;
    localparam int GCM_WIN_CYC     = (GCM_WIN_NS * GCM_SYS_MHZ) / 1000;
    // Register map, word aligned byte offsets
    localparam logic [7:0] GCM_OFS_CTRL   = 8'h00;
    localparam logic [7:0] GCM_OFS_RATIO  = 8'h04;
    localparam logic [7:0] GCM_OFS_RANGE  = 8'h08;
    localparam logic [7:0] GCM_OFS_SRC_LO = 8'h0c;
    localparam logic [7:0] GCM_OFS_SRC_HI = 8'h10;
    localparam logic [7:0] GCM_OFS_REGION = 8'h14;
    localparam logic [7:0] GCM_OFS_STAT   = 8'h18;
    localparam logic [7:0] GCM_OFS_DUAL   = 8'h1c;
    // Control fields
    localparam int GCM_CTRL_ENA    = 0;
    localparam int GCM_CTRL_ARST   = 1;
    localparam int GCM_CTRL_PFD    = 2;
    localparam logic [31:0] GCM_CTRL_RST   = 32'h0000_0004;
    // Ratio and range reset values (mult, div; min, max in counts)
    localparam logic [31:0] GCM_RATIO_RST  = 32'h0001_0001;
    localparam logic [31:0] GCM_RANGE_RST  = 32'hffff_0000;
    localparam logic [31:0] GCM_SRC_RST    = 32'h0000_0000;
    localparam logic [31:0] GCM_REGION_RST = 32'h0000_0000;
    // Source selection codes per global line
    typedef enum logic [2:0] {
        GCM_SRC_DED    = 3'h0,
        GCM_SRC_DUAL   = 3'h1,
        GCM_SRC_PLL    = 3'h2,
        GCM_SRC_FABRIC = 3'h3,
        GCM_SRC_OFF    = 3'h4
    } gcm_src_t;
    // Lock state machine
    typedef enum logic [1:0] {
        GCM_ST_DOWN = 2'h0,
        GCM_ST_WAIT = 2'h1,
        GCM_ST_LOCK = 2'h2
    } gcm_lock_t;
    // Dedicated pin feeding each line: 0,1,0,1,2,3,2,3
    localparam logic [15:0] GCM_DED_MAP  = 16'hee44;
    // Dual-use pin feeding each line: 2,7,1,0,3,6,4,5
    localparam logic [23:0] GCM_DUAL_MAP = 24'hb3307a;
endpackage : gcm_pkg

// ### logic/gcm_pll_model.sv
// Digital PLL model: lock tracking and gated output clocks
module gcm_pll_model
    import gcm_pkg::*;
#(
    parameter int LOCK_DELAY = GCM_LOCK_DEF
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // Loop control
    input  wire logic        loop_ena_i,
    input  wire logic        loop_arst_i,
    input  wire logic        pfd_ena_i,
    // Reference edge and range verdict
    input  wire logic        ref_edge_i,
    input  wire logic        freq_ok_i,
    input  wire logic        freq_chg_i,
    input  wire logic        ref_clk_i,
    // Outputs
    output logic [1:0]       pll_clk_o,
    output logic             locked_o
);
    gcm_lock_t   st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        run_q;
    logic        kill, valid;
    logic [3:0]  lock_cnt;

    assign lock_cnt = 4'(LOCK_DELAY);
    assign kill     = !loop_ena_i || loop_arst_i;
    assign valid    = freq_ok_i && pfd_ena_i;

    // Lock sequencing
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            GCM_ST_DOWN: begin
                cnt_d = 4'h0;
                if (valid) st_d = GCM_ST_WAIT;
            end
            GCM_ST_WAIT: begin
                if (!valid) st_d = GCM_ST_DOWN;
                else if (ref_edge_i) begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q + 4'h1 >= lock_cnt) st_d = GCM_ST_LOCK;
                end
            end
            GCM_ST_LOCK: begin
                if (!freq_ok_i || freq_chg_i) st_d = GCM_ST_DOWN;
            end
            default: st_d = GCM_ST_DOWN;
        endcase
        if (kill) st_d = GCM_ST_DOWN;
    end

    // State registers
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q  <= GCM_ST_DOWN;
            cnt_q <= 4'h0;
            run_q <= 1'b0;
        end else if (ce_i) begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            // Outputs keep running with detector off once established
            if (kill) run_q <= 1'b0;
            else if (st_d == GCM_ST_LOCK) run_q <= 1'b1;
        end
    end

    // Lock not forced low while detector disabled is a legal undefined choice
    assign locked_o  = (st_q == GCM_ST_LOCK) && !kill;
    assign pll_clk_o = {2{run_q & ref_clk_i & !kill}};

    property p_lock_win;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        kill |=> !locked_o;
    endproperty
    a_lock_win: assert property (p_lock_win) else $error("lock held while loop off");
    property p_off_low;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        loop_arst_i |-> pll_clk_o == 2'b00;
    endproperty
    a_off_low: assert property (p_off_low) else $error("pll clock not low in reset");
    sequence s_held;
        run_q && !kill && pfd_ena_i == 1'b0;
    endsequence
    property p_keep_run;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_held ##1 (ce_i && !kill) |-> run_q;
    endproperty
    a_keep_run: assert property (p_keep_run) else $error("outputs stopped, detector off");
    property p_no_early;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(locked_o) |-> cnt_q >= 4'(GCM_LOCK_MIN);
    endproperty
    a_no_early: assert property (p_no_early) else $error("lock too early");
    property p_range;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (ce_i && !freq_ok_i) |=> !locked_o;
    endproperty
    a_range: assert property (p_range) else $error("lock held out of range");
    property p_after_rst;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        $fell(loop_arst_i) |-> !locked_o;
    endproperty
    a_after_rst: assert property (p_after_rst) else $error("lock immediately after reset");
endmodule : gcm_pll_model

// ### logic/gcm_clock_mux.sv
// Global clock line sources, PLL model and register slave
//
// How it works
// - Loop enable low drops lock and forces PLL clocks low.
// - Loop reset high drops lock and holds PLL clocks low.
// - Detector off keeps PLL clocks running; lock then undefined.
// - Lock rises 2 to 10 reference cycles after a valid condition.
// - Reference frequency times mult over div outside range drops lock.
// - Eight global lines, each reaching every consumer.
// - Lines fed from dedicated pins, dual-use pins or PLL outputs.
// - Fabric logic may also drive any global line.
// - Lines carry control signals from pins as well as clocks.
// - Each dedicated pin selectable as PLL reference or direct source.
// - Dedicated pins 0,1,2,3 feed lines 0/2, 1/3, 4/6, 5/7.
// - Dual-use pins feed lines 3,2,0,4,6,7,5,1 respectively.
// - An unused dual-use pin is ordinary input, output or bidirectional.
// - Dual-use pins distribute high-fanout controls over global lines.
// - Six of eight lines per region; cluster picks two of six.
module gcm_clock_mux
    import gcm_pkg::*;
#(
    parameter int LOCK_DELAY = GCM_LOCK_DEF,
    parameter int WIN_CYC    = GCM_WIN_CYC
) (
    // Clock, reset, enable
    input  wire logic                     sys_clk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     ce_i,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic [31:0]                   wb_dat_o,
    output logic                          wb_ack_o,
    // Pins and fabric sources
    input  wire logic [GCM_NUM_DED-1:0]   ded_clk_i,
    input  wire logic [GCM_NUM_DUAL-1:0]  dual_use_clock_pins_i,
    output logic [GCM_NUM_DUAL-1:0]       dual_use_clock_pins_o,
    output logic [GCM_NUM_DUAL-1:0]       dual_use_clock_pins_oe_o,
    input  wire logic [GCM_NUM_DUAL-1:0]  dual_io_dat_i,
    output logic [GCM_NUM_DUAL-1:0]       dual_io_dat_o,
    input  wire logic [GCM_NUM_LINES-1:0] fabric_src_i,
    // Global lines and region buses
    output logic [GCM_NUM_LINES-1:0]      global_net_line_o,
    output logic [GCM_REGION_W-1:0]       region_bus_o,
    output logic [GCM_CLUSTER_W-1:0]      logic_cluster_clk_o,
    // PLL status
    output logic [1:0]                    pll_clk_o,
    output logic                          pll_locked_o
);
    // Registers
    logic [31:0] ctrl_q, ratio_q, range_q, src_lo_q, src_hi_q, region_q, dual_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    // Reference measurement
    logic [2:0]  ref_sync_q;
    logic        ref_edge;
    logic [15:0] win_q, cnt_q, fin_q;
    logic [31:0] vco_est;
    logic        freq_ok_q, freq_chg_q;
    // Decode wires
    logic        wb_req, wb_wr;
    logic [1:0]  pll_clk;
    logic        pll_locked;
    logic [1:0]  ref_pick;
    logic        ref_clk;
    logic [31:0] wmask;

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Register writes land on the edge at which the master sees ack high
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q   <= GCM_CTRL_RST;
            ratio_q  <= GCM_RATIO_RST;
            range_q  <= GCM_RANGE_RST;
            src_lo_q <= GCM_SRC_RST;
            src_hi_q <= GCM_SRC_RST;
            region_q <= GCM_REGION_RST;
            dual_q   <= GCM_SRC_RST;
            ack_q    <= 1'b0;
        end else if (ce_i) begin
            ack_q <= wb_req;
            if (wb_wr) begin
                unique case (wb_adr_i)
                    GCM_OFS_CTRL:   ctrl_q   <= (ctrl_q & ~wmask) | (wb_dat_i & wmask);
                    GCM_OFS_RATIO:  ratio_q  <= (ratio_q & ~wmask) | (wb_dat_i & wmask);
                    GCM_OFS_RANGE:  range_q  <= (range_q & ~wmask) | (wb_dat_i & wmask);
                    GCM_OFS_SRC_LO: src_lo_q <= (src_lo_q & ~wmask) | (wb_dat_i & wmask);
                    GCM_OFS_SRC_HI: src_hi_q <= (src_hi_q & ~wmask) | (wb_dat_i & wmask);
                    GCM_OFS_REGION: region_q <= (region_q & ~wmask) | (wb_dat_i & wmask);
                    GCM_OFS_DUAL:   dual_q   <= (dual_q & ~wmask) | (wb_dat_i & wmask);
                    default: ;
                endcase
            end
        end
    end

    // Read data, unmapped reads zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) rdat_q <= 32'h0;
        else if (ce_i && wb_req) begin
            unique case (wb_adr_i)
                GCM_OFS_CTRL:   rdat_q <= ctrl_q;
                GCM_OFS_RATIO:  rdat_q <= ratio_q;
                GCM_OFS_RANGE:  rdat_q <= range_q;
                GCM_OFS_SRC_LO: rdat_q <= src_lo_q;
                GCM_OFS_SRC_HI: rdat_q <= src_hi_q;
                GCM_OFS_REGION: rdat_q <= region_q;
                GCM_OFS_STAT:   rdat_q <= {fin_q, 13'h0, freq_ok_q, pll_clk != 2'b00, pll_locked};
                GCM_OFS_DUAL:   rdat_q <= dual_q;
                default:        rdat_q <= 32'h0;
            endcase
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Reference pin chosen from the dedicated pins
    assign ref_pick = ctrl_q[9:8];
    assign ref_clk  = ded_clk_i[ref_pick];

    // Reference pin synchroniser, edge once stages two and three agree high
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) ref_sync_q <= 3'b000;
        else if (ce_i) ref_sync_q <= {ref_sync_q[1:0], ref_clk};
    end
    logic ref_lvl_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) ref_lvl_q <= 1'b0;
        else if (ce_i && ref_sync_q[2] == ref_sync_q[1]) ref_lvl_q <= ref_sync_q[2];
    end
    assign ref_edge = ce_i && ref_sync_q[2] && ref_sync_q[1] && !ref_lvl_q;

    // Frequency estimate: reference edges per window times mult over div
    assign vco_est = (ratio_q[15:0] == 16'h0) ? 32'h0 :
                     ({16'h0, fin_q} * {16'h0, ratio_q[31:16]}) / {16'h0, ratio_q[15:0]};
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            win_q      <= 16'h0;
            cnt_q      <= 16'h0;
            fin_q      <= 16'h0;
            freq_ok_q  <= 1'b0;
            freq_chg_q <= 1'b0;
        end else if (ce_i) begin
            freq_chg_q <= 1'b0;
            if (win_q == 16'(WIN_CYC - 1)) begin
                win_q      <= 16'h0;
                cnt_q      <= {15'h0, ref_edge};
                fin_q      <= cnt_q;
                freq_chg_q <= (cnt_q != fin_q);
            end else begin
                win_q <= win_q + 16'h1;
                cnt_q <= cnt_q + {15'h0, ref_edge};
            end
            freq_ok_q <= (vco_est >= {16'h0, range_q[15:0]}) &&
                         (vco_est <= {16'h0, range_q[31:16]});
        end
    end

    gcm_pll_model #(
        .LOCK_DELAY (LOCK_DELAY)
    ) u_pll (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .ce_i        (ce_i),
        .loop_ena_i  (ctrl_q[GCM_CTRL_ENA]),
        .loop_arst_i (ctrl_q[GCM_CTRL_ARST]),
        .pfd_ena_i   (ctrl_q[GCM_CTRL_PFD]),
        .ref_edge_i  (ref_edge),
        .freq_ok_i   (freq_ok_q),
        .freq_chg_i  (freq_chg_q),
        .ref_clk_i   (ref_clk),
        .pll_clk_o   (pll_clk),
        .locked_o    (pll_locked)
    );
    assign pll_clk_o    = pll_clk;
    assign pll_locked_o = pll_locked;

    // Per-line source selection, combinational so clocks pass through
    genvar g;
    generate
        for (g = 0; g < GCM_NUM_LINES; g++) begin : g_line
            logic [2:0] sel;
            logic [1:0] ded_idx;
            logic [2:0] dual_idx;
            logic       ded_ok;
            assign sel      = (g < 4) ? src_lo_q[3*(g%4) +: 3] : src_hi_q[3*(g%4) +: 3];
            assign ded_idx  = GCM_DED_MAP[2*g +: 2];
            assign dual_idx = GCM_DUAL_MAP[3*g +: 3];
            // A pin routed to the PLL reference no longer drives lines directly while the loop is enabled
            assign ded_ok   = !(ctrl_q[GCM_CTRL_ENA] && ref_pick == ded_idx);
            assign global_net_line_o[g] =
                (sel == GCM_SRC_DED)    ? (ded_clk_i[ded_idx] & ded_ok) :
                (sel == GCM_SRC_DUAL)   ? (dual_use_clock_pins_i[dual_idx] & dual_q[dual_idx]) :
                (sel == GCM_SRC_PLL)    ? pll_clk[g%2] :
                (sel == GCM_SRC_FABRIC) ? fabric_src_i[g] :
                1'b0;
        end
    endgenerate

    // Dual-use pins as plain I/O when not a global source
    assign dual_use_clock_pins_o    = dual_io_dat_i;
    assign dual_use_clock_pins_oe_o = ~dual_q[7:0] & dual_q[15:8];
    assign dual_io_dat_o            = dual_use_clock_pins_i;

    // Region bus: six lines picked by 3-bit indices, cluster picks two
    generate
        for (g = 0; g < GCM_REGION_W; g++) begin : g_region
            assign region_bus_o[g] = global_net_line_o[region_q[3*g +: 3]];
        end
        for (g = 0; g < GCM_CLUSTER_W; g++) begin : g_cluster
            logic [2:0] idx;
            assign idx = region_q[18 + 3*g +: 3];
            assign logic_cluster_clk_o[g] = (idx < 3'(GCM_REGION_W)) ? region_bus_o[idx] : 1'b0;
        end
    endgenerate

    // Bus answer: one ack, one enabled cycle after the request

    property p_ack_one;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (wb_ack_o && ce_i) |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

    property p_ack_next;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i) |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");

    // Dedicated pin map and reference blocking

    property p_ded_map;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (src_lo_q[2:0] == 3'h0 && !(ctrl_q[0] && ref_pick == 2'h0)) |-> global_net_line_o[0] == ded_clk_i[0];
    endproperty
    a_ded_map: assert property (p_ded_map) else $error("line 0 not from dedicated pin 0");

    property p_ded_hi;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (src_hi_q[5:3] == 3'h0 && !(ctrl_q[0] && ref_pick == 2'h3)) |-> global_net_line_o[5] == ded_clk_i[3];
    endproperty
    a_ded_hi: assert property (p_ded_hi) else $error("line 5 not from dedicated pin 3");

    property p_ref_block;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (ctrl_q[GCM_CTRL_ENA] && ref_pick == 2'h0 && src_lo_q[2:0] == 3'h0) |-> !global_net_line_o[0];
    endproperty
    a_ref_block: assert property (p_ref_block) else $error("reference pin still on line 0");

    // Dual-use, PLL and fabric sources

    property p_dual_map;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (src_lo_q[2:0] == 3'h1 && dual_q[2]) |-> global_net_line_o[0] == dual_use_clock_pins_i[2];
    endproperty
    a_dual_map: assert property (p_dual_map) else $error("line 0 not from dual pin 2");

    property p_dual_hi;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (src_hi_q[5:3] == 3'h1 && dual_q[6]) |-> global_net_line_o[5] == dual_use_clock_pins_i[6];
    endproperty
    a_dual_hi: assert property (p_dual_hi) else $error("line 5 not from dual pin 6");

    property p_pll_line;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        src_lo_q[8:6] == 3'h2 |-> global_net_line_o[2] == pll_clk[0];
    endproperty
    a_pll_line: assert property (p_pll_line) else $error("line 2 not from pll clock 0");

    property p_fabric;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        src_hi_q[11:9] == 3'h3 |-> global_net_line_o[7] == fabric_src_i[7];
    endproperty
    a_fabric: assert property (p_fabric) else $error("fabric not on line 7");

    property p_dual_io;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        dual_q[0] |-> !dual_use_clock_pins_oe_o[0];
    endproperty
    a_dual_io: assert property (p_dual_io) else $error("global dual pin driven");

    // Region and cluster selection

    property p_region;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        region_q[2:0] == 3'h7 |-> region_bus_o[0] == global_net_line_o[7];
    endproperty
    a_region: assert property (p_region) else $error("region slot 0 not from line 7");

    property p_cluster;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        region_q[23:21] >= 3'h6 |-> !logic_cluster_clk_o[1];
    endproperty
    a_cluster: assert property (p_cluster) else $error("out of range cluster slot not low");
endmodule : gcm_clock_mux

// ### verification/gcm_board_model.sv
// Board side model: reference clock and pin drivers
module gcm_board_model (
    // Controls from the bench
    input  wire logic       run_i,
    input  wire logic [7:0] half_ns_i,
    input  wire logic [3:0] ded_stat_i,
    input  wire logic [7:0] dual_ext_i,
    // Device side of the dual-use pins
    input  wire logic [7:0] dual_o_i,
    input  wire logic [7:0] dual_oe_i,
    output logic      [3:0] ded_clk_o,
    output logic      [7:0] dual_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_q = 1'b0;

    // Reference off the system clock phase; held low while stopped
    initial begin
        #3;
        forever begin
            #(half_ns_i);
            ref_q = run_i ? ~ref_q : 1'b0;
        end
    end

    // Pin 0 carries the reference, others static levels
    assign ded_clk_o  = {ded_stat_i[3:1], run_i ? ref_q : ded_stat_i[0]};
    // Wire level: device drive where enabled, board drive elsewhere
    assign dual_pin_o = (dual_oe_i & dual_o_i) | (~dual_oe_i & dual_ext_i);
endmodule : gcm_board_model

// ### verification/tb_top.sv
// Testbench for global clock line selection and PLL model
module tb_top;
    import gcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk  = 1'b0;
    logic        rstn     = 1'b0;
    logic        ce       = 1'b1;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic [3:0]  sel      = 4'hf;
    logic [31:0] wdat     = 32'h0;
    logic [31:0] rdat;
    logic [3:0]  ded_stat = 4'h0;
    logic [7:0]  dual_ext = 8'h00;
    logic [7:0]  io_dat   = 8'h00;
    logic [7:0]  fab      = 8'h00;
    logic [7:0]  half     = 8'h10;
    logic        run      = 1'b0;
    logic [31:0] wb_dat;
    logic        wb_ack;
    logic [3:0]  ded;
    logic [7:0]  pin;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe;
    logic [7:0]  io_o;
    logic [7:0]  lines;
    logic [5:0]  rbus;
    logic [1:0]  cl;
    logic [1:0]  pll;
    logic        lock;
    logic [2:0]  hi;
    logic [2:0]  lo;
    int          err_total = 0;
    int          n_tests   = 0;
    int          ref_cnt   = 0;
    int          n0;
    int          i;
    int          p;
    // Line-to-pin tables for dedicated and dual-use sources
    int          ded_of[8]  = '{0, 1, 0, 1, 2, 3, 2, 3};
    int          dual_of[8] = '{2, 7, 1, 0, 3, 6, 4, 5};
    logic [7:0]  rofs[7] = '{GCM_OFS_CTRL, GCM_OFS_RATIO, GCM_OFS_RANGE, GCM_OFS_SRC_LO,
                             GCM_OFS_SRC_HI, GCM_OFS_REGION, 8'h20};
    logic [31:0] rval[7] = '{GCM_CTRL_RST, GCM_RATIO_RST, GCM_RANGE_RST, GCM_SRC_RST,
                             GCM_SRC_RST, GCM_REGION_RST, 32'h0};
    logic [31:0] kill[2] = '{32'h0000_0004, 32'h0000_0007};

    // Clock generation
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Reference edge counter
    always @(posedge ded[0]) begin
        ref_cnt++;
    end

    gcm_clock_mux #(.LOCK_DELAY(4), .WIN_CYC(16)) i_gcm_clock_mux (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
        .ded_clk_i(ded), .dual_use_clock_pins_i(pin), .dual_use_clock_pins_o(pin_o),
        .dual_use_clock_pins_oe_o(pin_oe), .dual_io_dat_i(io_dat), .dual_io_dat_o(io_o),
        .fabric_src_i(fab), .global_net_line_o(lines), .region_bus_o(rbus),
        .logic_cluster_clk_o(cl), .pll_clk_o(pll), .pll_locked_o(lock)
    );

    gcm_board_model i_gcm_board_model (
        .run_i(run), .half_ns_i(half), .ded_stat_i(ded_stat), .dual_ext_i(dual_ext),
        .dual_o_i(pin_o), .dual_oe_i(pin_oe), .ded_clk_o(ded), .dual_pin_o(pin)
    );

    // Verdict and end of run
    task automatic summarize;
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask : chk

    // One classic Wishbone cycle; read data lands in rdat
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rdat = wb_dat;
        cyc  <= 1'b0;
        stb  <= 1'b0;
        we   <= 1'b0;
        if (n >= 50) begin
            err_total++;
            summarize();
        end
    endtask : bus

    // Bounded wait for a lock level
    task automatic wait_lock(input logic v, input int lim);
        int n;
        n = 0;
        while (lock !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            summarize();
        end
    endtask : wait_lock

    // Collect levels seen on lock and PLL clocks
    task automatic watch(input int c);
        hi = 3'b000;
        lo = 3'b000;
        repeat (c) begin
            @(posedge sys_clk);
            hi = hi | {lock, pll};
            lo = lo | ~{lock, pll};
        end
    endtask : watch

    // Lines expected high when source pin p is the only one high
    function automatic logic [7:0] exp_lines(input int t[8], input int p);
        logic [7:0] e;
        for (int l = 0; l < 8; l++) begin
            e[l] = (t[l] == p);
        end
        return e;
    endfunction : exp_lines

    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            bus(1'b0, rofs[i], 32'h0);
            chk(rdat, rval[i]);
        end
        for (p = 0; p < 4; p++) begin
            @(posedge sys_clk);
            ded_stat <= 4'h1 << p;
            @(posedge sys_clk);
            chk(lines, exp_lines(ded_of, p));
        end
        bus(1'b1, GCM_OFS_DUAL, 32'h0000_00ff);
        bus(1'b1, GCM_OFS_SRC_LO, 32'h0000_0249);
        bus(1'b1, GCM_OFS_SRC_HI, 32'h0000_0249);
        for (p = 0; p < 8; p++) begin
            @(posedge sys_clk);
            dual_ext <= 8'h01 << p;
            @(posedge sys_clk);
            chk(lines, exp_lines(dual_of, p));
            chk(pin_oe, 8'h00);
        end
        bus(1'b1, GCM_OFS_SRC_LO, 32'h0000_06db);
        bus(1'b1, GCM_OFS_SRC_HI, 32'h0000_06db);
        fab <= 8'h5a;
        bus(1'b1, GCM_OFS_REGION, {8'h00, 3'd6, 3'd3, 3'd2, 3'd3, 3'd4, 3'd5, 3'd6, 3'd7});
        @(posedge sys_clk);
        chk(lines, 8'h5a);
        // Region slots take lines 7..2; cluster slot 3 then an out-of-range slot
        chk(rbus, 6'h1a);
        chk(cl, 2'b01);
        bus(1'b1, GCM_OFS_DUAL, 32'h0000_0f00);
        io_dat   <= 8'h36;
        dual_ext <= 8'hc9;
        @(posedge sys_clk);
        chk(pin_oe, 8'h0f);
        chk(pin_o, 8'h36);
        chk(io_o, 8'hc6);
        // Reference running well before the loop is enabled
        run <= 1'b1;
        repeat (100) @(posedge sys_clk);
        bus(1'b1, GCM_OFS_CTRL, 32'h0000_0005);
        n0 = ref_cnt;
        wait_lock(1'b1, 400);
        chk((ref_cnt - n0) >= 2 && (ref_cnt - n0) <= 10, 1'b1);
        bus(1'b0, GCM_OFS_STAT, 32'h0);
        chk(rdat[0], 1'b1);
        // Reference pin 0 must not reach lines 0 and 2 while the loop runs
        bus(1'b1, GCM_OFS_SRC_LO, 32'h0000_0000);
        repeat (4) begin
            @(posedge sys_clk);
            chk(lines[3:0], 4'h0);
        end
        bus(1'b1, GCM_OFS_SRC_LO, 32'h0000_0492);
        repeat (6) begin
            @(posedge sys_clk);
            chk(lines[3:0], {pll, pll});
        end
        watch(40);
        chk({hi[1:0], lo[1:0]}, 4'hf);
        bus(1'b1, GCM_OFS_CTRL, 32'h0000_0001);
        watch(40);
        chk({hi[1:0], lo[1:0]}, 4'hf);
        bus(1'b1, GCM_OFS_CTRL, 32'h0000_0005);
        wait_lock(1'b1, 400);
        bus(1'b1, GCM_OFS_RANGE, 32'h0001_0000);
        wait_lock(1'b0, 100);
        chk(lock, 1'b0);
        bus(1'b1, GCM_OFS_RANGE, GCM_RANGE_RST);
        wait_lock(1'b1, 400);
        chk(lock, 1'b1);
        // Slower reference, still resolvable by the pin filter: two edges a window
        half <= 8'h20;
        wait_lock(1'b0, 100);
        chk(lock, 1'b0);
        wait_lock(1'b1, 400);
        chk(lock, 1'b1);
        for (i = 0; i < 2; i++) begin
            bus(1'b1, GCM_OFS_CTRL, kill[i]);
            repeat (2) @(posedge sys_clk);
            watch(30);
            chk(hi, 3'b000);
            bus(1'b1, GCM_OFS_CTRL, 32'h0000_0005);
            wait_lock(1'b1, 400);
        end
        summarize();
    end
endmodule : tb_top
